// ===== core/mcu_instruction_subset_exec.sv
// Execution core for a subset of a 4-bit microcontroller instruction set.
`timescale 1ns/10ps
`include "isx_cfg.svh"

module mcu_instruction_subset_exec
    import isx_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic [9:0]  insn_word,
    input  wire logic        insn_valid,
    input  wire port_in_s    port_in,
    input  wire bus_req_s    bus,
    output logic [31:0]      rdata,
    output logic             mcycle,
    output logic [13:0]      pc,
    output logic             irq_enabled,
    output logic             inte_flag,
    output osc_sel_e         osc_sel,
    output logic             onchip_osc_on,
    output logic             wdt_run,
    output logic             wdt_restart,
    output logic             pd_clock_run,
    output logic             pd_ram_backup
);

    // Instruction field decoders; only is_imm_to_acc is used in more than one place.
    function automatic logic is_imm_to_acc(input logic [9:0] w);
        is_imm_to_acc = (w[9:4] == `OP_IMM_ACC_TOP);
    endfunction

    function automatic logic is_call_far(input logic [9:0] w);
        is_call_far = (w[9:5] == `OP_CALL_FAR_TOP);
    endfunction

    function automatic logic is_read_port(input logic [9:0] w);
        is_read_port = (w[9:3] == `OP_READ_PORT_TOP) && (w[2:0] <= 3'h4);
    endfunction

    function automatic nibble_t port_pick(input port_in_s p, input logic [2:0] s);
        case (s)
            3'h0:    port_pick = p.p0;
            3'h1:    port_pick = p.p1;
            3'h2:    port_pick = p.p2;
            3'h3:    port_pick = p.p3;
            default: port_pick = p.p4;
        endcase
    endfunction

    logic        rst_meta_n;
    logic        rst_sync_n;
    logic [7:0]  div_reg;
    logic        mcycle_reg;
    call_state_e call_state_reg;
    logic [6:0]  page_reg;
    logic        indexed_reg;
    logic [13:0] pc_reg;
    logic [13:0] stack_mem [0:7];
    logic [2:0]  stack_pointer_reg;
    nibble_t     acc_reg;
    nibble_t     y_reg;
    logic [2:0]  d_reg;
    logic        skip_reg;
    logic        imm_run_reg;
    logic        pd_arm_reg;
    logic        inte_reg;
    logic        irq_eff_reg;
    logic        wdt_arm_reg;
    logic        wdt_run_reg;
    logic        wdt_restart_reg;
    logic        pd_run_reg;
    logic        pd_ram_reg;
    osc_sel_e    osc_reg;
    logic        onchip_reg;
    logic        large_reg;
    logic        perr_reg;
    logic [31:0] rdata_reg;

    // Reset is released through two flops so that removal is clean.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // Machine cycle enable from a divider of the core clock.
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            div_reg    <= 8'h00;
            mcycle_reg <= 1'b0;
        end else if (div_reg == 8'(`MCYCLE_DIV - 1)) begin
            div_reg    <= 8'h00;
            mcycle_reg <= 1'b1;
        end else begin
            div_reg    <= div_reg + 8'h01;
            mcycle_reg <= 1'b0;
        end
    end

    // A word is consumed once per machine cycle when the fetch side offers one.
    logic step;
    logic exec;
    logic second;
    logic [6:0] page_max;
    logic [6:0] call_low;
    nibble_t y_dec;
    nibble_t y_inc;

    assign step     = mcycle_reg && insn_valid;
    assign second   = step && (call_state_reg == CALL_SECOND);
    assign exec     = step && !skip_reg && (call_state_reg == CALL_IDLE);
    assign page_max = large_reg ? `PAGE_MAX_LARGE : `PAGE_MAX_MID;
    assign call_low = indexed_reg ? {d_reg, acc_reg} : insn_word[6:0];
    assign y_dec    = y_reg - 4'h1;
    assign y_inc    = y_reg + 4'h1;

    // Page operand from the second word of a far call; the direct form takes its low five bits from the first.
    logic [6:0] page_full;
    always_comb begin
        if (indexed_reg) begin
            page_full = {insn_word[8:6], insn_word[3:0]};
        end else begin
            page_full = {insn_word[8:7], page_reg[4:0]};
        end
    end

    // Far call sequencing: first word latches, second word completes.
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            call_state_reg <= CALL_IDLE;
            page_reg       <= 7'h00;
            indexed_reg    <= 1'b0;
        end else begin
            case (call_state_reg)
                CALL_IDLE: begin
                    if (exec && is_call_far(insn_word)) begin
                        call_state_reg <= CALL_SECOND;
                        page_reg       <= {2'b00, insn_word[4:0]};
                        indexed_reg    <= 1'b0;
                    end else if (exec && (insn_word == `OP_CALL_FAR_IDX)) begin
                        call_state_reg <= CALL_SECOND;
                        indexed_reg    <= 1'b1;
                    end
                end
                CALL_SECOND: begin
                    if (step) begin
                        call_state_reg <= CALL_IDLE;
                    end
                end
                default: begin
                    call_state_reg <= CALL_IDLE;
                end
            endcase
        end
    end

    // Program counter: advances per word, jumps on completion of a far call.
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pc_reg <= `PC_RST;
        end else if (second) begin
            pc_reg <= {page_full, call_low};
        end else if (step) begin
            pc_reg <= pc_reg + 14'h0001;
        end
    end

    // Return stack push; the return address is the word after the call.
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            stack_pointer_reg <= `STACK_POINTER_RST;
        end else if (second) begin
            stack_pointer_reg <= stack_pointer_reg + 3'h1;
        end
    end

    // Stack slots carry no reset; only written slots are ever meaningful.
    always_ff @(posedge core_clk) begin
        if (second) begin
            stack_mem[stack_pointer_reg + 3'h1] <= pc_reg + 14'h0001;
        end
    end

    // Page range check; an out-of-range call still executes but is flagged.
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            perr_reg <= 1'b0;
        end else if (second && (page_full > page_max)) begin
            perr_reg <= 1'b1;
        end else if (bus.wr && (bus.addr == `OFS_CTRL) && bus.wdata[`CTRL_PERR_CLR]) begin
            perr_reg <= 1'b0;
        end
    end

    // Accumulator updates.
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            acc_reg <= `ACC_RST;
        end else if (exec) begin
            if (is_imm_to_acc(insn_word) && !imm_run_reg) begin
                acc_reg <= insn_word[3:0];
            end else if (insn_word == `OP_ACC_INVERT) begin
                acc_reg <= ~acc_reg;
            end else if (is_read_port(insn_word)) begin
                acc_reg <= port_pick(port_in, insn_word[2:0]);
            end
        end
    end

    // Run of immediate loads: any other executed or skipped word ends it.
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            imm_run_reg <= 1'b0;
        end else if (step) begin
            imm_run_reg <= exec && is_imm_to_acc(insn_word);
        end
    end

    // Y register increment and decrement.
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            y_reg <= `Y_RST;
        end else if (exec && (insn_word == `OP_Y_DEC)) begin
            y_reg <= y_dec;
        end else if (exec && (insn_word == `OP_Y_INC)) begin
            y_reg <= y_inc;
        end
    end

    // Skip discards exactly the next word consumed.
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            skip_reg <= 1'b0;
        end else if (exec && (insn_word == `OP_Y_DEC)) begin
            skip_reg <= (y_dec == 4'hf);
        end else if (exec && (insn_word == `OP_Y_INC)) begin
            skip_reg <= (y_inc == 4'h0);
        end else if (step) begin
            skip_reg <= 1'b0;
        end
    end

    // Interrupt enable flag and its effective copy one machine cycle later.
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            inte_reg    <= 1'b0;
            irq_eff_reg <= 1'b0;
        end else begin
            if (exec && (insn_word == `OP_IRQ_MASK)) begin
                inte_reg <= 1'b0;
            end else if (exec && (insn_word == `OP_IRQ_UNMASK)) begin
                inte_reg <= 1'b1;
            end
            if (mcycle_reg) begin
                irq_eff_reg <= inte_reg;
            end
        end
    end

    // Main clock source selection.
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            osc_reg    <= OSC_ONCHIP;
            onchip_reg <= 1'b1;
        end else if (exec && (insn_word == `OP_CERAMIC_OSC)) begin
            osc_reg    <= OSC_CERAMIC;
            onchip_reg <= 1'b0;
        end else if (exec && (insn_word == `OP_RC_OSC)) begin
            osc_reg    <= OSC_RC;
            onchip_reg <= 1'b0;
        end
    end

    // Watchdog stop arming; a restart after arming halts the watchdog.
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            wdt_arm_reg     <= 1'b0;
            wdt_run_reg     <= 1'b1;
            wdt_restart_reg <= 1'b0;
        end else begin
            wdt_restart_reg <= exec && (insn_word == `OP_WDT_RESTART);
            if (exec && (insn_word == `OP_WDT_STOP_ARM)) begin
                wdt_arm_reg <= 1'b1;
            end
            if (exec && (insn_word == `OP_WDT_RESTART) && wdt_arm_reg) begin
                wdt_run_reg <= 1'b0;
            end
        end
    end

    // Power-down arming lasts exactly one executed instruction.
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pd_arm_reg <= 1'b0;
            pd_run_reg <= 1'b0;
            pd_ram_reg <= 1'b0;
        end else begin
            pd_run_reg <= exec && pd_arm_reg && (insn_word == `OP_PD_CLOCK_RUN);
            pd_ram_reg <= exec && pd_arm_reg && (insn_word == `OP_PD_RAM_BACKUP);
            if (step) begin
                pd_arm_reg <= exec && (insn_word == `OP_PD_ARM);
            end
        end
    end

    // Software-written configuration: ROM variant and index register.
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            large_reg <= 1'b0;
            d_reg     <= 3'h0;
        end else if (bus.wr) begin
            if (bus.addr == `OFS_CTRL) begin
                large_reg <= bus.wdata[`CTRL_LARGE_BIT];
            end
            if (bus.addr == `OFS_DREG) begin
                d_reg <= bus.wdata[2:0];
            end
        end
    end

    // Read data stand only in the cycle after the strobe; unmapped reads zero.
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rdata_reg <= 32'h0000_0000;
        end else if (bus.rd) begin
            case (bus.addr)
                `OFS_CTRL:   rdata_reg <= {31'h0, large_reg};
                `OFS_DREG:   rdata_reg <= {29'h0, d_reg};
                `OFS_STATUS: rdata_reg <= {22'h0, perr_reg, pd_arm_reg, wdt_arm_reg,
                                           wdt_run_reg, onchip_reg, osc_reg,
                                           irq_eff_reg, inte_reg};
                `OFS_CORE:   rdata_reg <= {2'h0, pc_reg, 3'h0, skip_reg,
                                           1'b0, stack_pointer_reg, y_reg, acc_reg};
                `OFS_STACK_TOP: rdata_reg <= {18'h0, stack_mem[stack_pointer_reg]};
                default:     rdata_reg <= 32'h0000_0000;
            endcase
        end else begin
            rdata_reg <= 32'h0000_0000;
        end
    end

    // All outputs come straight from flops.
    assign rdata         = rdata_reg;
    assign mcycle        = mcycle_reg;
    assign pc            = pc_reg;
    assign irq_enabled   = irq_eff_reg;
    assign inte_flag     = inte_reg;
    assign osc_sel       = osc_reg;
    assign onchip_osc_on = onchip_reg;
    assign wdt_run       = wdt_run_reg;
    assign wdt_restart   = wdt_restart_reg;
    assign pd_clock_run  = pd_run_reg;
    assign pd_ram_backup = pd_ram_reg;

endmodule

// ===== core/isx_cfg.svh
// Offsets, opcodes, reset values and timing counts for the instruction subset core.
//
// Behaviour
// - Far direct call increments stack pointer, saves PC, loads page and 7-bit offset.
// - Return stack holds eight nesting levels; deeper calls wrap and overwrite.
// - Call page limit is 95 on the mid variant, 127 on the large one.
// - Ceramic select switches main clock to ceramic and stops on-chip oscillator.
// - RC select switches main clock to RC and stops on-chip oscillator.
// - Y increment wraps modulo sixteen and skips next word when result is 0.
// - Interrupt mask clears enable flag; effect lags by one machine cycle.
// - Interrupt unmask sets enable flag; effect lags by one machine cycle.
// - Watchdog stop arm makes a later watchdog restart halt the watchdog.
// - Power-down arm validates the immediately following power-down instruction.
// - A power-down instruction without the arm just before it is a no-op.
// - Immediate load writes its 4-bit value 0 to 15 into the accumulator.
// - In a run of consecutive immediate loads only the first takes effect.
`ifndef ISX_CFG_SVH
`define ISX_CFG_SVH

// Register byte offsets.
`define OFS_CTRL       8'h00
`define OFS_DREG       8'h04
`define OFS_STATUS     8'h08
`define OFS_CORE       8'h0c
`define OFS_STACK_TOP  8'h10

// Control register fields.
`define CTRL_LARGE_BIT 0
`define CTRL_PERR_CLR  1

// Opcodes and opcode fields.
`define OP_CALL_FAR_TOP  5'h06
`define OP_CALL_FAR_IDX  10'h030
`define OP_ACC_INVERT    10'h01c
`define OP_CERAMIC_OSC   10'h29a
`define OP_RC_OSC        10'h29b
`define OP_Y_DEC         10'h017
`define OP_Y_INC         10'h013
`define OP_IRQ_MASK      10'h004
`define OP_IRQ_UNMASK    10'h005
`define OP_WDT_STOP_ARM  10'h29c
`define OP_WDT_RESTART   10'h2a0
`define OP_PD_ARM        10'h05b
`define OP_PD_CLOCK_RUN  10'h002
`define OP_PD_RAM_BACKUP 10'h008
`define OP_READ_PORT_TOP 7'h4c
`define OP_IMM_ACC_TOP   6'h07

// Page limits per ROM variant.
`define PAGE_MAX_MID   7'd95
`define PAGE_MAX_LARGE 7'd127

// Reset values.
`define STACK_POINTER_RST 3'h7
`define Y_RST          4'h0
`define ACC_RST        4'h0
`define PC_RST         14'h0000

// Machine cycle timing.
`define CLK_PERIOD_NS  5
`define MCYCLE_NS      20
`define MCYCLE_DIV     ((`MCYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== core/isx_pkg.sv
// Types shared by the instruction subset core.
package isx_pkg;
    typedef logic [3:0] nibble_t;

    // Five 4-bit input ports.
    typedef struct packed {
        nibble_t p4;
        nibble_t p3;
        nibble_t p2;
        nibble_t p1;
        nibble_t p0;
    } port_in_s;

    // Register bus request.
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_s;

    // Far call sequencing.
    typedef enum logic [1:0] {
        CALL_IDLE   = 2'b01,
        CALL_SECOND = 2'b10
    } call_state_e;

    // Main clock source.
    typedef enum logic [2:0] {
        OSC_ONCHIP  = 3'b001,
        OSC_CERAMIC = 3'b010,
        OSC_RC      = 3'b100
    } osc_sel_e;
endpackage

// ===== dv/mcu_instruction_subset_exec_chk.sv
// Concurrent checks on the ports of the instruction subset core.
`timescale 1ns/10ps
`include "isx_cfg.svh"

module mcu_instruction_subset_exec_chk
    import isx_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic [9:0]  insn_word,
    input wire logic        insn_valid,
    input wire port_in_s    port_in,
    input wire bus_req_s    bus,
    input wire logic [31:0] rdata,
    input wire logic        mcycle,
    input wire logic [13:0] pc,
    input wire logic        irq_enabled,
    input wire logic        inte_flag,
    input wire osc_sel_e    osc_sel,
    input wire logic        onchip_osc_on,
    input wire logic        wdt_run,
    input wire logic        wdt_restart,
    input wire logic        pd_clock_run,
    input wire logic        pd_ram_backup
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // A step is an offered word on a machine cycle edge; pc, the enable flag and the clock source move only on one.
    wire logic step_w = mcycle & insn_valid;

    mcycle_period_a: assert property (mcycle |=> !mcycle [*3] ##1 mcycle)
        else $error("machine cycle spacing wrong");
    pc_on_step_a: assert property ($changed(pc) |-> $past(step_w))
        else $error("pc moved without a step");
    irq_on_lag_a: assert property ($rose(inte_flag) |->
        !irq_enabled [*4] ##1 irq_enabled) else $error("interrupt enable lag wrong");
    irq_off_lag_a: assert property ($fell(inte_flag) |->
        irq_enabled [*4] ##1 !irq_enabled) else $error("interrupt disable lag wrong");
    inte_on_step_a: assert property ($changed(inte_flag) |-> $past(step_w))
        else $error("enable flag moved without a step");
    osc_stop_a: assert property (osc_sel != OSC_ONCHIP |-> !onchip_osc_on)
        else $error("on-chip oscillator left running");
    osc_on_step_a: assert property ($changed(osc_sel) |-> $past(step_w))
        else $error("clock source moved without a step");
    pd_clock_cause_a: assert property (pd_clock_run |->
        $past(insn_word) == `OP_PD_CLOCK_RUN && $past(step_w) ##1 !pd_clock_run)
        else $error("clock-run power-down bad");
    pd_ram_cause_a: assert property (pd_ram_backup |->
        $past(insn_word) == `OP_PD_RAM_BACKUP && $past(step_w) ##1 !pd_ram_backup)
        else $error("back-up power-down bad");
    wdt_pulse_a: assert property (wdt_restart |->
        $past(insn_word) == `OP_WDT_RESTART && $past(step_w))
        else $error("watchdog restart pulse bad");
    wdt_halt_a: assert property ($fell(wdt_run) |->
        $past(insn_word) == `OP_WDT_RESTART) else $error("watchdog halted without restart");
endmodule

bind mcu_instruction_subset_exec mcu_instruction_subset_exec_chk chk (
    .core_clk(core_clk), .rst_n(rst_n), .insn_word(insn_word), .insn_valid(insn_valid),
    .port_in(port_in), .bus(bus), .rdata(rdata), .mcycle(mcycle), .pc(pc),
    .irq_enabled(irq_enabled), .inte_flag(inte_flag), .osc_sel(osc_sel),
    .onchip_osc_on(onchip_osc_on), .wdt_run(wdt_run), .wdt_restart(wdt_restart),
    .pd_clock_run(pd_clock_run), .pd_ram_backup(pd_ram_backup));

// ===== dv/tb_mcu_instruction_subset_exec.sv
// Self-checking bench for the instruction subset core.
`timescale 1ns/10ps
`include "isx_cfg.svh"

module tb_mcu_instruction_subset_exec
    import isx_pkg::*;
;
    localparam logic [19:0] PORT_LEVELS = 20'h17c3e;
    logic        core_clk;
    logic        rst_n;
    logic [9:0]  insn_word;
    logic        insn_valid;
    port_in_s    port_in;
    bus_req_s    bus;
    logic [31:0] rdata;
    logic        mcycle;
    logic [13:0] pc;
    logic        irq_enabled;
    logic        inte_flag;
    osc_sel_e    osc_sel;
    logic        onchip_osc_on;
    logic        wdt_run;
    logic        wdt_restart;
    logic        pd_clock_run;
    logic        pd_ram_backup;
    logic [31:0] v;
    int          err_count;
    int          tests_run;
    int          cycles;

    mcu_instruction_subset_exec dut (
        .core_clk(core_clk), .rst_n(rst_n), .insn_word(insn_word), .insn_valid(insn_valid),
        .port_in(port_in), .bus(bus), .rdata(rdata), .mcycle(mcycle), .pc(pc),
        .irq_enabled(irq_enabled), .inte_flag(inte_flag), .osc_sel(osc_sel),
        .onchip_osc_on(onchip_osc_on), .wdt_run(wdt_run), .wdt_restart(wdt_restart),
        .pd_clock_run(pd_clock_run), .pd_ram_backup(pd_ram_backup));

    // Clock at 200 MHz.
    always #2.5 core_clk = ~core_clk;

    // Cut a hang short; the whole run needs well under this many cycles.
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            test_done();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("errors %0d of %0d checks", err_count, tests_run);
        if (err_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Offer one word and hold it until the machine cycle edge that takes it.
    task automatic step(input logic [9:0] w);
        int n;
        @(posedge core_clk);
        insn_word <= w;
        insn_valid <= 1'b1;
        #1;
        for (n = 0; n < 12 && mcycle !== 1'b1; n++) begin
            @(posedge core_clk);
            #1;
        end
        @(posedge core_clk);
        insn_valid <= 1'b0;
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus <= {a, d, 1'b1, 1'b0};
        @(posedge core_clk);
        bus <= '0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        bus <= {a, 32'h0, 1'b0, 1'b1};
        @(posedge core_clk);
        bus <= '0;
        #1;
        d = rdata;
    endtask

    task automatic call(input logic [9:0] w1, input logic [9:0] w2, input logic [13:0] t);
        logic [13:0] p0;
        p0 = pc;
        step(w1);
        check(pc, p0 + 14'd1);
        step(w2);
        check(pc, t);
        rd(`OFS_STACK_TOP, v);
        check(v, {18'h0, p0 + 14'd2});
    endtask

    // Main sequence; reset is held for two cycles first.
    initial begin
        core_clk = 0;
        rst_n = 0;
        insn_word = '0;
        insn_valid = 0;
        port_in = PORT_LEVELS;
        bus = '0;
        err_count = 0;
        tests_run = 0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        check(onchip_osc_on, 1);
        check(wdt_run, 1);
        rd(`OFS_CORE, v);
        check(v[10:8], `STACK_POINTER_RST);
        step({`OP_IMM_ACC_TOP, 4'h5});
        step({`OP_IMM_ACC_TOP, 4'h9});
        rd(`OFS_CORE, v);
        check(v[3:0], 4'h5);
        step(`OP_ACC_INVERT);
        rd(`OFS_CORE, v);
        check(v[3:0], 4'ha);
        step({`OP_IMM_ACC_TOP, 4'hf});
        rd(`OFS_CORE, v);
        check(v[3:0], 4'hf);
        for (int i = 0; i < 5; i++) begin
            step({`OP_READ_PORT_TOP, 3'(i)});
            rd(`OFS_CORE, v);
            check(v[3:0], PORT_LEVELS[i*4 +: 4]);
        end
        // Each skipping step swallows the load behind it.
        step(`OP_Y_DEC);
        step({`OP_IMM_ACC_TOP, 4'h7});
        rd(`OFS_CORE, v);
        check(v[7:0], 8'hf1);
        step(`OP_Y_INC);
        step({`OP_IMM_ACC_TOP, 4'h7});
        rd(`OFS_CORE, v);
        check(v[7:0], 8'h01);
        step(`OP_Y_INC);
        step({`OP_IMM_ACC_TOP, 4'h7});
        rd(`OFS_CORE, v);
        check(v[7:0], 8'h17);
        step(`OP_Y_DEC);
        step({`OP_IMM_ACC_TOP, 4'h4});
        rd(`OFS_CORE, v);
        check(v[7:0], 8'h04);
        // Far calls: page 96 is over the mid-variant limit.
        wr(`OFS_DREG, 32'h5);
        wr(`OFS_CTRL, 32'h0);
        call({`OP_CALL_FAR_TOP, 5'd0}, {1'b1, 2'b11, 7'h2a}, {7'd96, 7'h2a});
        rd(`OFS_STATUS, v);
        check(v[9], 1);
        rd(`OFS_CORE, v);
        check(v[10:8], 3'h0);
        wr(`OFS_CTRL, 32'h3);
        call(`OP_CALL_FAR_IDX, {1'b1, 3'b111, 2'b00, 4'hf}, {7'd127, 7'h54});
        rd(`OFS_STATUS, v);
        check(v[9], 0);
        for (int i = 0; i < 8; i++)
            call({`OP_CALL_FAR_TOP, 5'd3}, {1'b1, 2'b00, 7'(i)}, {7'd3, 7'(i)});
        rd(`OFS_CORE, v);
        check(v[10:8], 3'h1);
        step(`OP_IRQ_UNMASK);
        check({inte_flag, irq_enabled}, 2'b10);
        repeat (4) @(posedge core_clk);
        #1;
        check(irq_enabled, 1);
        step(`OP_IRQ_MASK);
        check({inte_flag, irq_enabled}, 2'b01);
        repeat (4) @(posedge core_clk);
        #1;
        check(irq_enabled, 0);
        step(`OP_CERAMIC_OSC);
        check({osc_sel, onchip_osc_on}, {OSC_CERAMIC, 1'b0});
        step(`OP_RC_OSC);
        check({osc_sel, onchip_osc_on}, {OSC_RC, 1'b0});
        step(`OP_WDT_RESTART);
        check({wdt_restart, wdt_run}, 2'b11);
        step(`OP_WDT_STOP_ARM);
        step(`OP_WDT_RESTART);
        check(wdt_run, 0);
        step(`OP_PD_CLOCK_RUN);
        check(pd_clock_run, 0);
        step(`OP_PD_ARM);
        step(`OP_PD_CLOCK_RUN);
        check(pd_clock_run, 1);
        step(`OP_PD_ARM);
        step(`OP_ACC_INVERT);
        step(`OP_PD_RAM_BACKUP);
        check(pd_ram_backup, 0);
        step(`OP_PD_ARM);
        step(`OP_PD_RAM_BACKUP);
        check(pd_ram_backup, 1);
        rd(8'h40, v);
        check(v, 32'h0);
        test_done();
    end
endmodule
